//--- output_sequence_engine.sv
`timescale 1ns/1ps
`default_nettype none
module output_sequence_engine import oseq_pkg::*; #(
    parameter int TICK_CYCLES = TICK_CYC      // clocks per 0.1 ms base tick
) (
    input  wire logic        pclk,            // apb clock
    input  wire logic        presetn,         // async reset, low
    input  wire logic        psel,            // apb select
    input  wire logic        penable,         // apb enable
    input  wire logic        pwrite,          // apb direction
    input  wire logic [7:0]  paddr,           // apb byte address
    input  wire logic [31:0] pwdata,          // apb write data
    output logic      [31:0] prdata,          // apb read data
    output logic             pready,          // apb ready
    output logic             pslverr,         // unmapped address
    input  wire logic        supply_cc,       // supply in constant current
    input  wire logic        supply_fast,     // supply in fast cv / dynamic cc
    input  wire logic        trig_in,         // trigger terminal input level
    output logic      [15:0] setpoint,        // sequenced setpoint
    output logic             output_on,       // output enable to supply
    output logic             trig_out,        // trigger pulse, one cycle
    output logic             trig_oe,         // terminal driven as output
    output logic             running          // sequence active
);
    // ****************************************
    // state and helpers
    // ****************************************
    st_t              s;
    st_t              n;
    step_t            stp;
    seq_ent_t         e;
    prog_ent_t        pg;
    logic [19:0]      uticks;
    logic [15:0]      tmax;
    logic [15:0]      total;
    logic [15:0]      el1;
    logic [10:0]      idx1;
    logic [10:0]      lim;
    logic             setup;
    logic             wr;
    logic             ctrlw;
    logic             go;
    logic             stopw;
    logic             resw;
    logic signed [33:0] prod;
    logic signed [33:0] rq;

    // current step, sequence and program entries
    assign pg    = s.prgt[s.prog];
    assign stp   = s.mem[10'(pg.base + s.idx[9:0])];
    assign e     = s.seqt[{s.fast, s.seq}];
    assign setup = psel & ~penable;
    assign wr    = psel & penable & s.rdy & pwrite & ~s.serr;
    assign ctrlw = wr && (paddr == A_CTRL);
    assign go    = ctrlw && pwdata[C_START];
    assign stopw = ctrlw && pwdata[C_STOP];
    assign resw  = ctrlw && pwdata[C_RESUME];
    assign idx1  = s.idx + 11'h001;
    assign el1   = s.el + 16'h0001;
    assign lim   = s.fast ? FSTEP_MAX : NSTEP_MAX;
    assign total = s.fast ? 16'h0001 : stp.time_v;

    // ramp interpolation; only used while total is nonzero
    assign prod = 34'($signed({1'b0, stp.sp}) - $signed({1'b0, s.start}))
                  * $signed({18'h0, el1});
    assign rq   = prod / $signed({18'h0, total});

    // ****************************************
    // time base per unit
    // ****************************************
    // fast mode uses the fixed step time directly in 0.1 ms ticks
    always_comb begin
        uticks = U_MS;
        tmax   = T_MAX4;
        if (s.fast) begin
            uticks = {10'h000, s.ftime};
            tmax   = 16'h0001;
        end else begin
            case (unit_t'(s.unit))
                UN_MS: begin
                    uticks = U_MS;
                    tmax   = T_MAX4;
                end
                UN_DS: begin
                    uticks = U_DS;
                    tmax   = T_MAX4;
                end
                UN_S: begin
                    uticks = U_S;
                    tmax   = T_MAX5;
                end
                UN_MIN: begin
                    uticks = U_MIN;
                    tmax   = T_MAX5;
                end
                default: begin
                    uticks = U_MS;
                    tmax   = T_MAX4;
                end
            endcase
        end
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        n      = s;
        n.tout = 1'b0;
        n.rdy  = psel & ~s.rdy;
        // read data is fetched in the setup cycle so prdata is a flop
        if (setup) begin
            n.serr  = 1'b0;
            n.rdata = 32'h0000_0000;
            case (paddr)
                A_CTRL:  n.rdata = {17'h0, s.sel, 2'h0, s.unit, 2'h0, s.tdir, s.cur,
                                    s.fast, 3'h0};
                A_STAT:  n.rdata = {5'h0, s.idx, 4'h0, s.prog, 1'b0, s.st, 1'b0,
                                    s.refused, s.st == S_PAUSE, s.run};
                A_FTIME: n.rdata = {22'h0, s.ftime};
                A_SEQA:  n.rdata = {28'h0, s.seqa};
                A_SEQD:  n.rdata = {6'h0, s.seqt[s.seqa]};
                A_PRGA:  n.rdata = {28'h0, s.prga};
                A_PRGD:  n.rdata = {11'h0, s.prgt[s.prga]};
                A_STPA:  n.rdata = {22'h0, s.stpa};
                A_STPD:  n.rdata = s.mem[s.stpa][31:0];
                A_STPF:  n.rdata = {28'h0, s.mem[s.stpa][35:32]};
                default: n.serr  = 1'b1;
            endcase
        end
        // register writes; mode and unit freeze while a run is active
        if (wr) begin
            case (paddr)
                A_CTRL: begin
                    if (!s.run) begin
                        n.fast = pwdata[C_FAST];
                        n.cur  = pwdata[C_CUR];
                        n.tdir = pwdata[C_TDIR];
                        n.unit = pwdata[C_UNIT +: 2];
                        n.sel  = pwdata[C_SEL +: 3];
                    end
                end
                A_FTIME: n.ftime = pwdata[9:0];
                A_SEQA:  n.seqa  = pwdata[3:0];
                A_SEQD:  n.seqt[s.seqa] = seq_ent_t'(pwdata[25:0]);
                A_PRGA:  n.prga  = pwdata[3:0];
                A_PRGD:  n.prgt[s.prga] = prog_ent_t'(pwdata[20:0]);
                A_STPA:  n.stpa  = pwdata[9:0];
                A_STPF:  n.stpf  = pwdata[3:0];
                A_STPD: begin
                    n.mem[s.stpa] = {s.stpf, pwdata};
                    n.stpa        = s.stpa + 10'h001;
                end
                default: n.serr = s.serr;
            endcase
        end
        // terminal direction: fast mode forces output
        n.toe = n.fast | n.tdir;
        case (s.st)
            S_IDLE: begin
                if (go) begin
                    if ((n.cur != supply_cc) || (n.fast && !supply_fast)
                        || (n.fast && (s.ftime < FTIME_MIN || s.ftime > FTIME_MAX))) begin
                        n.refused = 1'b1;
                    end else begin
                        n.refused = 1'b0;
                        n.run     = 1'b1;
                        n.on      = n.fast | s.on;
                        n.seq     = n.sel;
                        n.st      = S_SEQ;
                    end
                end
            end
            S_SEQ: begin
                n.prog  = e.prog;
                n.loops = e.loops;
                n.idx   = 11'h000;
                n.endph = 1'b0;
                n.st    = S_STEP;
                if (e.loops == 14'h0000 || e.loops > LOOP_INF) begin
                    n.refused = 1'b1;
                    n.run     = 1'b0;
                    n.st      = S_IDLE;
                end
            end
            S_STEP: begin
                if (pg.count == 11'h000 || pg.count > lim
                    || (!s.fast && stp.time_v > tmax)) begin
                    n.refused = 1'b1;
                    n.run     = 1'b0;
                    n.st      = S_IDLE;
                end else if (!s.fast && stp.time_v == 16'h0000) begin
                    n.st = S_NEXT;
                end else begin
                    n.start = s.sp;
                    if (s.fast || !stp.ramp) begin
                        n.sp = stp.sp;
                    end
                    n.on   = s.fast | stp.on;
                    n.tout = stp.trig & s.toe;
                    n.cyc  = 15'h0000;
                    n.sub  = 20'h00000;
                    n.el   = 16'h0000;
                    n.st   = (!s.fast && stp.pause) ? S_PAUSE : S_RUN;
                end
            end
            S_PAUSE: begin
                // an input-configured terminal can release the pause too
                if (resw || (trig_in && !s.toe)) begin
                    n.st = S_RUN;
                end
            end
            S_RUN: begin
                if (s.cyc == 15'(TICK_CYCLES - 1)) begin
                    n.cyc = 15'h0000;
                    if (s.sub == uticks - 20'h00001) begin
                        n.sub = 20'h00000;
                        n.el  = el1;
                        if (!s.fast && stp.ramp) begin
                            n.sp = 16'($signed({18'h0, s.start}) + rq);
                        end
                        if (el1 == total) begin
                            n.sp = stp.sp;
                            n.st = S_NEXT;
                        end
                    end else begin
                        n.sub = s.sub + 20'h00001;
                    end
                end else begin
                    n.cyc = s.cyc + 15'h0001;
                end
            end
            S_NEXT: begin
                if (s.endph) begin
                    if (e.chain_en) begin
                        n.seq = e.chain;
                        n.st  = S_SEQ;
                    end else begin
                        n.run = 1'b0;
                        n.st  = S_IDLE;
                    end
                end else if (idx1 < pg.count) begin
                    n.idx = idx1;
                    n.st  = S_STEP;
                end else if (s.loops == LOOP_INF) begin
                    n.idx = 11'h000;
                    n.st  = S_STEP;
                end else if (s.loops > 14'h0001) begin
                    n.loops = s.loops - 14'h0001;
                    n.idx   = 11'h000;
                    n.st    = S_STEP;
                end else begin
                    n.endph = 1'b1;
                    n.prog  = e.endp;
                    n.idx   = 11'h000;
                    n.st    = S_STEP;
                end
            end
            default: n.st = S_IDLE;
        endcase
        // stop wins over every state
        if (stopw) begin
            n.run = 1'b0;
            n.st  = S_IDLE;
        end
    end

    // one register bank for all state; tables reset to empty
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign prdata    = s.rdata;
    assign pready    = s.rdy;
    assign pslverr   = s.serr;
    assign setpoint  = s.sp;
    assign output_on = s.on;
    assign trig_out  = s.tout;
    assign trig_oe   = s.toe;
    assign running   = s.run;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    fast_on_a: assert property (s.run && s.fast |-> output_on)
        else $error("output off during fast run");
    cv_cc_a: assert property (s.st == S_IDLE && go && pwdata[C_CUR] != supply_cc
        |=> !running && s.refused)
        else $error("wrong quantity mode started");
    fast_ok_a: assert property (s.st == S_IDLE && go && pwdata[C_FAST] && !supply_fast
        |=> !running ##1 !running)
        else $error("fast run without fast supply");
    zero_skip_a: assert property (s.st == S_STEP && !s.fast && stp.time_v == 16'h0000
        && pg.count != 11'h000 && pg.count <= lim && !stopw |=> s.st == S_NEXT)
        else $error("zero time step executed");
    imm_step_a: assert property (s.st == S_STEP && (s.fast || !stp.ramp)
        && (n.st == S_RUN || n.st == S_PAUSE) |=> setpoint == $past(stp.sp))
        else $error("step change not immediate");
    trig_dir_a: assert property (trig_out |-> trig_oe)
        else $error("trigger pulse on input terminal");
    step_lim_a: assert property (s.st == S_RUN |-> pg.count <= lim && pg.count != 11'h000)
        else $error("program length out of range");
    inf_loop_a: assert property (s.st == S_NEXT && !s.endph && !stopw && idx1 >= pg.count
        && s.loops == LOOP_INF |=> s.st == S_STEP && s.idx == 11'h000 && s.loops == LOOP_INF)
        else $error("endless loop ended");
    end_one_a: assert property (s.st == S_NEXT && s.endph && !stopw
        |=> s.st == S_SEQ || s.st == S_IDLE)
        else $error("end program ran past first step");
    advance_a: assert property (s.st == S_NEXT && !s.endph && !stopw && idx1 < pg.count
        |=> s.st == S_STEP && s.idx == $past(idx1))
        else $error("step did not advance");
endmodule
`default_nettype wire

//--- oseq_pkg.sv
`default_nettype none
package oseq_pkg;
    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [7:0] A_CTRL  = 8'h00;
    localparam logic [7:0] A_STAT  = 8'h04;
    localparam logic [7:0] A_FTIME = 8'h08;
    localparam logic [7:0] A_SEQA  = 8'h0C;
    localparam logic [7:0] A_SEQD  = 8'h10;
    localparam logic [7:0] A_PRGA  = 8'h14;
    localparam logic [7:0] A_PRGD  = 8'h18;
    localparam logic [7:0] A_STPA  = 8'h1C;
    localparam logic [7:0] A_STPD  = 8'h20;
    localparam logic [7:0] A_STPF  = 8'h24;
    // control register bit positions
    localparam int C_START  = 0;
    localparam int C_STOP   = 1;
    localparam int C_RESUME = 2;
    localparam int C_FAST   = 3;
    localparam int C_CUR    = 4;
    localparam int C_TDIR   = 5;
    localparam int C_UNIT   = 8;
    localparam int C_SEL    = 12;
    // ****************************************
    // limits and timing
    // ****************************************
    localparam logic [13:0] LOOP_INF  = 14'h270F;
    localparam logic [10:0] NSTEP_MAX = 11'h100;
    localparam logic [10:0] FSTEP_MAX = 11'h400;
    localparam logic [9:0]  FTIME_MIN = 10'h001;
    localparam logic [9:0]  FTIME_MAX = 10'h3E8;
    localparam int          CLK_MHZ   = 200;
    localparam int          TICK_US   = 100;
    localparam int          TICK_CYC  = TICK_US * CLK_MHZ;
    localparam logic [19:0] U_MS   = 20'h0000A;
    localparam logic [19:0] U_DS   = 20'h003E8;
    localparam logic [19:0] U_S    = 20'h02710;
    localparam logic [19:0] U_MIN  = 20'h927C0;
    localparam logic [15:0] T_MAX4 = 16'h270F;
    localparam logic [15:0] T_MAX5 = 16'hEA5F;
    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {UN_MS = 2'b00, UN_DS = 2'b01, UN_S = 2'b10, UN_MIN = 2'b11} unit_t;
    typedef enum logic [2:0] {
        S_IDLE  = 3'b000,
        S_SEQ   = 3'b001,
        S_STEP  = 3'b010,
        S_PAUSE = 3'b011,
        S_RUN   = 3'b100,
        S_NEXT  = 3'b101
    } seq_state_t;
    typedef struct packed {
        logic [13:0] loops;
        logic        chain_en;
        logic [2:0]  chain;
        logic [3:0]  endp;
        logic [3:0]  prog;
    } seq_ent_t;
    typedef struct packed {
        logic [10:0] count;
        logic [9:0]  base;
    } prog_ent_t;
    typedef struct packed {
        logic        pause;
        logic        on;
        logic        trig;
        logic        ramp;
        logic [15:0] time_v;
        logic [15:0] sp;
    } step_t;
    typedef struct packed {
        logic [31:0]           rdata;
        logic                  rdy;
        logic                  serr;
        logic                  fast;
        logic                  cur;
        logic                  tdir;
        logic [1:0]            unit;
        logic [2:0]            sel;
        logic [9:0]            ftime;
        logic [3:0]            seqa;
        logic [3:0]            prga;
        logic [9:0]            stpa;
        logic [3:0]            stpf;
        seq_ent_t [15:0]       seqt;
        prog_ent_t [15:0]      prgt;
        step_t [1023:0]        mem;
        seq_state_t            st;
        logic                  refused;
        logic [2:0]            seq;
        logic [3:0]            prog;
        logic [10:0]           idx;
        logic [13:0]           loops;
        logic                  endph;
        logic [14:0]           cyc;
        logic [19:0]           sub;
        logic [15:0]           el;
        logic [15:0]           start;
        logic [15:0]           sp;
        logic                  on;
        logic                  tout;
        logic                  toe;
        logic                  run;
    } st_t;
endpackage
`default_nettype wire

//--- trig_partner.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// external trigger equipment model
// ****************************************
module trig_partner (
    input  wire logic       pclk,     // clock
    input  wire logic       presetn,  // reset, low
    input  wire logic       trig_out, // device trigger pulse
    input  wire logic       trig_oe,  // device drives the terminal
    input  wire logic       fire,     // bench asks for an input pulse
    output logic            trig_in,  // terminal level seen by device
    output logic      [7:0] pulses    // device pulses received
);
    // drive only while the device listens, so the terminal never has two drivers
    assign trig_in = trig_oe ? trig_out : fire;
    // count pulses only while the terminal is an output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulses <= 8'h00;
        end else if (trig_oe && trig_out) begin
            pulses <= pulses + 8'h01;
        end
    end
endmodule
`default_nettype wire

//--- output_sequence_engine_bench.sv
`timescale 1ns/1ps
`default_nettype none
module output_sequence_engine_bench import oseq_pkg::*;;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        supply_cc = 0, supply_fast = 0, fire = 0, saw_skip = 0, saw_mid = 0, lerr;
    logic [7:0]  paddr = 8'h00, pulses, p0;
    logic [31:0] pwdata = 32'h0, prdata, rq;
    logic        pready, pslverr, output_on, trig_out, trig_oe, running, trig_in;
    logic [15:0] setpoint;
    int          num_errors = 0, checked = 0;
    // ****************************************
    // clock, design and partner
    // ****************************************
    always #2.5 pclk = ~pclk;
    output_sequence_engine #(.TICK_CYCLES(4)) i_output_sequence_engine (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .supply_cc(supply_cc),
        .supply_fast(supply_fast), .trig_in(trig_in), .setpoint(setpoint),
        .output_on(output_on), .trig_out(trig_out), .trig_oe(trig_oe), .running(running));
    trig_partner i_trig_partner (.pclk(pclk), .presetn(presetn), .trig_out(trig_out),
        .trig_oe(trig_oe), .fire(fire), .trig_in(trig_in), .pulses(pulses));
    // a skipped step must never reach the output
    always @(posedge pclk) if (setpoint === 16'h1234) saw_skip <= 1'b1;
    // halfway value of the two-unit ramp from 0x321 to 0x443
    always @(posedge pclk) if (setpoint === 16'h03B2) saw_mid <= 1'b1;
    // ****************************************
    // shared tasks
    // ****************************************
    task chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask
    task wrap_up;
        if (num_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // one apb transfer; read data and error land in rq and lerr
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no cycle count assumed: only the watchdog ends a missing answer
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rq = prdata;
        lerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // c is {chain enable, chained sequence}
    task seq(input logic [3:0] i, p, e, input logic [13:0] lp, input logic [3:0] c);
        apb(1, A_SEQA, {28'h0, i});
        apb(1, A_SEQD, {6'h0, lp, c, e, p});
    endtask
    task prg(input logic [3:0] p, input logic [9:0] b, input logic [10:0] c);
        apb(1, A_PRGA, {28'h0, p});
        apb(1, A_PRGD, {11'h0, c, b});
    endtask
    task stp(input logic [9:0] a, input logic [3:0] f, input logic [15:0] t, s);
        apb(1, A_STPA, {22'h0, a});
        apb(1, A_STPF, {28'h0, f});
        apb(1, A_STPD, {t, s});
    endtask
    // fields first: they are ignored once a run is going
    task go(input logic [31:0] c);
        apb(1, A_CTRL, c);
        apb(1, A_CTRL, c | 32'h1);
    endtask
    task idle;
        repeat (4) @(posedge pclk);
        while (running !== 1'b0) begin
            @(posedge pclk);
        end
        apb(0, A_STAT, 0);
    endtask
    task wait_pause;
        int n;
        n = 0;
        do begin
            apb(0, A_STAT, 0);
            n++;
        end while (rq[6:4] !== 3'h3 && n < 500);
        chk(rq[6:4], 3'h3, "no pause");
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task t_store;
        chk({setpoint, output_on, trig_oe, running}, 0, "reset outputs");
        apb(0, 8'h28, 0);
        chk({lerr, rq[30:0]}, 32'h80000000, "unmapped");
        stp(10'h3FF, 4'hF, 16'hBEEF, 16'h1357);
        apb(1, A_STPA, 32'h3FF);
        apb(0, A_STPD, 0);
        chk(rq, 32'hBEEF1357, "step readback");
        prg(4'hF, 10'h3FF, 11'h400);
        apb(0, A_PRGD, 0);
        chk(rq, 32'h001003FF, "program readback");
    endtask
    task t_refuse;
        apb(1, A_FTIME, 32'h5);
        seq(0, 0, 0, 1, 0);
        prg(0, 0, 1);
        stp(0, 4'h4, 16'h1, 16'h0011);
        go(32'h10);
        idle;
        chk(rq[2:0], 3'h4, "cur mode taken");
        go(32'h08);
        idle;
        chk(rq[2:0], 3'h4, "fast taken");
        seq(0, 0, 0, 0, 0);
        go(0);
        idle;
        chk(rq[2:0], 3'h4, "zero loops");
        seq(0, 0, 0, 1, 0);
        prg(0, 0, 11'h101);
        go(0);
        idle;
        chk(rq[2:0], 3'h4, "long program");
    endtask
    task t_normal;
        stp(0, 4'h0, 16'h0000, 16'h1234);
        stp(1, 4'h6, 16'h0064, 16'h0055);
        stp(2, 4'h4, 16'h0001, 16'h0777);
        prg(0, 0, 2);
        prg(1, 2, 1);
        seq(0, 0, 1, 2, 0);
        p0 = pulses;
        go(32'h20);
        repeat (20) @(posedge pclk);
        chk(setpoint, 16'h0055, "first step");
        chk({output_on, trig_oe}, 2'b11, "on and out");
        idle;
        chk(setpoint, 16'h0777, "end step");
        chk(pulses - p0, 2, "normal pulses");
        chk(saw_skip, 0, "zero step ran");
    endtask
    task t_fast;
        supply_fast <= 1'b1;
        apb(1, A_FTIME, 32'h1);
        stp(3, 4'h2, 16'h0, 16'h0ABC);
        stp(4, 4'h2, 16'h0, 16'h0DEF);
        prg(2, 3, 2);
        seq(4'h8, 2, 2, 3, 0);
        p0 = pulses;
        go(32'h08);
        repeat (3) @(posedge pclk);
        chk({output_on, trig_oe}, 2'b11, "fast on/out");
        idle;
        chk(rq[2:0], 3'h0, "fast refused");
        chk(setpoint, 16'h0ABC, "fast end");
        chk(pulses - p0, 7, "fast pulses");
    endtask
    task t_pause;
        supply_fast <= 1'b0;
        supply_cc <= 1'b1;
        stp(5, 4'hC, 16'h1, 16'h0321);
        stp(6, 4'h5, 16'h2, 16'h0443);
        prg(3, 5, 1);
        prg(4, 6, 1);
        seq(1, 3, 4, 2, 0);
        go(32'h1010);
        wait_pause;
        repeat (50) @(posedge pclk);
        apb(0, A_STAT, 0);
        chk({rq[6:4], trig_oe}, 4'h6, "pause held");
        fire <= 1'b1;
        @(posedge pclk);
        fire <= 1'b0;
        wait_pause;
        apb(1, A_CTRL, 32'h1014);
        idle;
        chk(rq[2:0], 3'h0, "pause run");
        chk(setpoint, 16'h0443, "ramp end");
        chk(saw_mid, 1, "ramp midpoint");
    endtask
    // sequence 2 chains into sequence 3, which loops forever until stopped
    task t_chain;
        seq(2, 1, 1, 1, 4'hB);
        seq(3, 4, 1, LOOP_INF, 4'h0);
        go(32'h2010);
        repeat (2000) @(posedge pclk);
        apb(0, A_STAT, 0);
        chk({rq[11:8], rq[0]}, 5'h09, "no chain");
        repeat (2000) @(posedge pclk);
        chk(running, 1, "endless run ended");
        apb(1, A_CTRL, 32'h2012);
        idle;
        chk(rq[6:0], 0, "stop ignored");
    endtask
    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_store;
        t_refuse;
        t_normal;
        t_fast;
        t_pause;
        t_chain;
        wrap_up;
    end
    // generous bound: all scenarios take well under 30k cycles
    initial begin
        #250000;
        num_errors++;
        wrap_up;
    end
endmodule
`default_nettype wire
